/* logic/tmon_alarm_grp.sv */
// One threshold group: compares the selected sensor against its limit.
`default_nettype none

module tmon_alarm_grp
    import tmon_pkg::*;
#(
    parameter bit HIGH_SIDE = 1'b1
) (
    input wire logic [GRP_STEP-1:0] grp_cfg,
    input wire logic signed [12:0] temp_a,
    input wire logic signed [12:0] temp_b,
    output logic hit
);

    logic signed [12:0] limit;
    logic signed [12:0] temp_sel;
    logic arm;

    // The limit is a signed byte of whole degrees.
    assign limit = $signed({{5{grp_cfg[LIMIT_LSB+LIMIT_W-1]}}, grp_cfg[LIMIT_LSB +: LIMIT_W]});
    assign arm = grp_cfg[ARM_BIT];
    // RL9
    assign temp_sel = (grp_cfg[SRC_LSB +: SRC_W] == 2'h0) ? temp_a : temp_b;

    always_comb begin
        if (!arm) begin
            hit = 1'b0; // RL8
        end else if (HIGH_SIDE) begin
            hit = temp_sel > limit; // RL6
        end else begin
            hit = temp_sel < limit; // RL7
        end
    end

endmodule // tmon_alarm_grp

`default_nettype wire

/* logic/tmon_core.sv */
// Thermal monitor: sensor readout, threshold alarms and interrupt over APB.
//
// The implementer's own choice: the APB register port.
`default_nettype none

// Notes on behaviour
// RL1 - Both sensor readings appear together in one read-only sample register.
// RL2 - Sensor A over-range flag is set while its temperature exceeds 125 C.
// RL3 - Sensor B over-range flag sits at bit 25, set above 125 C.
// RL4 - Celsius equals raw times 731, divided by 0x4000, minus 273.
// RL5 - Four high and four low alarm groups, each limit, arm and source.
// RL6 - An armed high group fires when its sensor rises above the limit.
// RL7 - An armed low group fires when its sensor falls below the limit.
// RL8 - A group whose arm bit is zero never fires.
// RL9 - The source field picks sensor A with 0, sensor B otherwise.
// RL10 - High group 0: limit bits 7..0, arm bit 8, source bits 11..10.
// RL11 - High groups 1 to 3 repeat that layout every 16 bits.
// RL12 - The low alarm register uses the very same group layout.
// RL13 - Pending flags: bit 0 high alarm, bit 1 low alarm.
// RL14 - Any write to the pending register clears the pending flags.
// RL15 - Pending flags are sticky ORs of all armed groups of each kind.
// RL16 - One interrupt output is high while an enabled pending flag is set.
module tmon_core
    import tmon_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire tmon_apb_req_s apb_req,
    output tmon_apb_rsp_s apb_rsp,
    input wire logic [RAW_W-1:0] sensor_a_raw,
    input wire logic [RAW_W-1:0] sensor_b_raw,
    output logic thermal_irq
);

    typedef struct packed {
        logic sensor_a_over_range;
        logic sensor_b_over_range;
        logic [RAW_W-1:0] raw_a_last;
        logic [RAW_W-1:0] raw_b_last;
        logic [RAW_W-1:0] raw_a_ok;
        logic [RAW_W-1:0] raw_b_ok;
        logic [63:0] high_alarm_config;
        logic [63:0] low_alarm_config;
        logic [1:0] alarm_pending_flags;
        logic [1:0] irq_mask;
        logic [31:0] rdata;
        logic irq;
    } tmon_core_s;

    tmon_core_s st_r;
    tmon_core_s st_nxt;

    logic [RAW_W-1:0] raw_a_s;
    logic [RAW_W-1:0] raw_b_s;
    logic signed [12:0] temp_a;
    logic signed [12:0] temp_b;
    logic [GROUPS-1:0] high_hit;
    logic [GROUPS-1:0] low_hit;
    logic high_any;
    logic low_any;
    logic setup;
    logic access;
    logic wr;
    logic pend_clr;
    tmon_reg_e sel;

    // Each register word answers only at its exact word-aligned byte address.
    function automatic tmon_reg_e decode(input logic [31:0] addr);
        tmon_reg_e r;
        r = REG_NONE;
        if (addr == ADDR_SAMPLE_LO) begin
            r = REG_SAMPLE_LO;
        end else if (addr == ADDR_SAMPLE_HI) begin
            r = REG_SAMPLE_HI;
        end else if (addr == ADDR_HICFG_LO) begin
            r = REG_HICFG_LO;
        end else if (addr == ADDR_HICFG_HI) begin
            r = REG_HICFG_HI;
        end else if (addr == ADDR_LOCFG_LO) begin
            r = REG_LOCFG_LO;
        end else if (addr == ADDR_LOCFG_HI) begin
            r = REG_LOCFG_HI;
        end else if (addr == ADDR_PEND_LO) begin
            r = REG_PEND_LO;
        end else if (addr == ADDR_PEND_HI) begin
            r = REG_PEND_HI;
        end else if (addr == ADDR_MASK) begin
            r = REG_MASK;
        end
        return r;
    endfunction

    // The analog readings change with no relation to pclk.
    tmon_sync u_sync_a (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(sensor_a_raw),
        .sync_out(raw_a_s)
    );

    tmon_sync u_sync_b (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(sensor_b_raw),
        .sync_out(raw_b_s)
    );

    assign temp_a = raw_to_celsius(st_r.raw_a_ok); // RL4
    assign temp_b = raw_to_celsius(st_r.raw_b_ok); // RL4

    // Each group owns one 16-bit slice of its alarm register.
    for (genvar g = 0; g < GROUPS; g++) begin : g_grp
        // RL5
        tmon_alarm_grp #(
            .HIGH_SIDE(1'b1)
        ) u_high (
            .grp_cfg(st_r.high_alarm_config[g*GRP_STEP +: GRP_STEP]), // RL10 RL11
            .temp_a(temp_a),
            .temp_b(temp_b),
            .hit(high_hit[g])
        );

        tmon_alarm_grp #(
            .HIGH_SIDE(1'b0)
        ) u_low (
            .grp_cfg(st_r.low_alarm_config[g*GRP_STEP +: GRP_STEP]), // RL12
            .temp_a(temp_a),
            .temp_b(temp_b),
            .hit(low_hit[g])
        );
    end

    assign high_any = |high_hit; // RL15
    assign low_any = |low_hit; // RL15

    assign setup = apb_req.psel && !apb_req.penable;
    assign access = apb_req.psel && apb_req.penable;
    assign sel = decode(apb_req.paddr);
    assign wr = access && apb_req.pwrite;
    // Either word of the pending register clears it, whatever the data or strobes.
    assign pend_clr = wr && ((sel == REG_PEND_LO) || (sel == REG_PEND_HI)); // RL14

    always_comb begin
        st_nxt = st_r;

        st_nxt.sensor_a_over_range = temp_a > OVER_RANGE_C; // RL2
        st_nxt.sensor_b_over_range = temp_b > OVER_RANGE_C; // RL3

        // Each bit is synchronised on its own, so a reading caught mid-change may be
        // torn; a reading is taken only once two successive samples agree.
        st_nxt.raw_a_last = raw_a_s;
        st_nxt.raw_b_last = raw_b_s;
        if (raw_a_s == st_r.raw_a_last) begin
            st_nxt.raw_a_ok = raw_a_s; // RL4
        end
        if (raw_b_s == st_r.raw_b_last) begin
            st_nxt.raw_b_ok = raw_b_s; // RL4
        end

        // Read data is captured in the setup cycle so prdata comes from a flop.
        if (setup) begin
            unique case (sel)
                REG_NONE: st_nxt.rdata = RDATA_RESET;
                REG_SAMPLE_LO: begin
                    st_nxt.rdata = RDATA_RESET;
                    st_nxt.rdata[OVR_A_BIT] = st_r.sensor_a_over_range; // RL2
                    st_nxt.rdata[OVR_B_BIT] = st_r.sensor_b_over_range; // RL3
                end
                REG_SAMPLE_HI: st_nxt.rdata = {st_r.raw_b_ok, st_r.raw_a_ok}; // RL1
                REG_HICFG_LO: st_nxt.rdata = st_r.high_alarm_config[31:0];
                REG_HICFG_HI: st_nxt.rdata = st_r.high_alarm_config[63:32];
                REG_LOCFG_LO: st_nxt.rdata = st_r.low_alarm_config[31:0];
                REG_LOCFG_HI: st_nxt.rdata = st_r.low_alarm_config[63:32];
                REG_PEND_LO: st_nxt.rdata = {30'h0, st_r.alarm_pending_flags}; // RL13
                REG_PEND_HI: st_nxt.rdata = RDATA_RESET;
                REG_MASK: st_nxt.rdata = {30'h0, st_r.irq_mask};
                default: st_nxt.rdata = RDATA_RESET;
            endcase
        end

        // Reserved bits of the alarm registers are never stored and read back as zero.
        if (wr) begin
            unique case (sel)
                REG_HICFG_LO: begin
                    st_nxt.high_alarm_config[31:0] = apply_strb(
                        st_r.high_alarm_config[31:0], apb_req.pwdata, apb_req.pstrb)
                        & CFG_WMASK[31:0];
                end
                REG_HICFG_HI: begin
                    st_nxt.high_alarm_config[63:32] = apply_strb(
                        st_r.high_alarm_config[63:32], apb_req.pwdata, apb_req.pstrb)
                        & CFG_WMASK[63:32];
                end
                REG_LOCFG_LO: begin
                    st_nxt.low_alarm_config[31:0] = apply_strb(
                        st_r.low_alarm_config[31:0], apb_req.pwdata, apb_req.pstrb)
                        & CFG_WMASK[31:0];
                end
                REG_LOCFG_HI: begin
                    st_nxt.low_alarm_config[63:32] = apply_strb(
                        st_r.low_alarm_config[63:32], apb_req.pwdata, apb_req.pstrb)
                        & CFG_WMASK[63:32];
                end
                REG_MASK: begin
                    st_nxt.irq_mask = 2'(apply_strb({30'h0, st_r.irq_mask},
                        apb_req.pwdata, apb_req.pstrb));
                end
                default: begin
                    st_nxt.irq_mask = st_r.irq_mask;
                end
            endcase
        end

        // A condition present in the clearing cycle sets its flag again.
        st_nxt.alarm_pending_flags = pend_clr ? PEND_RESET : st_r.alarm_pending_flags; // RL14
        st_nxt.alarm_pending_flags[PEND_HIGH_BIT] =
            st_nxt.alarm_pending_flags[PEND_HIGH_BIT] | high_any; // RL13 RL15
        st_nxt.alarm_pending_flags[PEND_LOW_BIT] =
            st_nxt.alarm_pending_flags[PEND_LOW_BIT] | low_any; // RL13 RL15

        st_nxt.irq = |(st_nxt.alarm_pending_flags & st_nxt.irq_mask); // RL16
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{
                sensor_a_over_range: 1'b0,
                sensor_b_over_range: 1'b0,
                raw_a_last: RAW_RESET,
                raw_b_last: RAW_RESET,
                raw_a_ok: RAW_RESET,
                raw_b_ok: RAW_RESET,
                high_alarm_config: CFG_RESET,
                low_alarm_config: CFG_RESET,
                alarm_pending_flags: PEND_RESET,
                irq_mask: MASK_RESET,
                rdata: RDATA_RESET,
                irq: 1'b0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    // Zero wait states; unmapped addresses answer with an error.
    assign apb_rsp = '{
        prdata: st_r.rdata,
        pready: 1'b1,
        pslverr: access && (sel == REG_NONE)
    };
    assign thermal_irq = st_r.irq;

    AST_RAW_READ: assert property (@(posedge pclk) disable iff (!presetn) // RL1
        (setup && sel == REG_SAMPLE_HI)
        |=> apb_rsp.prdata == $past({st_r.raw_b_ok, st_r.raw_a_ok}))
        else $error("sample readout does not show both raw readings");

    AST_OVR_A: assert property (@(posedge pclk) disable iff (!presetn) // RL2
        st_r.sensor_a_over_range == $past(temp_a > OVER_RANGE_C))
        else $error("sensor A over-range flag wrong");

    AST_OVR_B_READ: assert property (@(posedge pclk) disable iff (!presetn) // RL3
        (setup && sel == REG_SAMPLE_LO)
        |=> apb_rsp.prdata[OVR_B_BIT] == $past(st_r.sensor_b_over_range)
            && apb_rsp.prdata[23:0] == 24'h0)
        else $error("sensor B over-range flag not at its bit");

    AST_HIGH_SET: assert property (@(posedge pclk) disable iff (!presetn) // RL6
        high_any |=> st_r.alarm_pending_flags[PEND_HIGH_BIT]
            && (thermal_irq || !st_r.irq_mask[PEND_HIGH_BIT]))
        else $error("high alarm did not set its flag");

    AST_LOW_SET: assert property (@(posedge pclk) disable iff (!presetn) // RL7
        low_any |=> st_r.alarm_pending_flags[PEND_LOW_BIT])
        else $error("low alarm did not set its flag");

    AST_DISARMED: assert property (@(posedge pclk) disable iff (!presetn) // RL8
        (!st_r.high_alarm_config[ARM_BIT] |-> !high_hit[0])
        and (!st_r.low_alarm_config[GRP_STEP+ARM_BIT] |-> !low_hit[1]))
        else $error("disarmed group produced a hit");

    AST_CLEAR: assert property (@(posedge pclk) disable iff (!presetn) // RL14
        (pend_clr && !high_any && !low_any) |=> st_r.alarm_pending_flags == 2'h0)
        else $error("status write did not clear pending flags");

    AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn) // RL15
        (st_r.alarm_pending_flags[PEND_LOW_BIT] && !pend_clr)
        |=> st_r.alarm_pending_flags[PEND_LOW_BIT])
        else $error("pending flag dropped without a status write");

    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn) // RL16
        thermal_irq == |(st_r.alarm_pending_flags & st_r.irq_mask))
        else $error("interrupt output disagrees with pending flags");

    AST_CFG_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // RL10
        (wr && sel == REG_HICFG_LO && apb_req.pstrb == 4'hf)
        |=> st_r.high_alarm_config[31:0] == ($past(apb_req.pwdata) & CFG_WMASK[31:0]))
        else $error("high alarm group write not stored");

    // Further checks on the readout, the alarm registers and the interrupt path.
    AST_OVR_B: assert property (@(posedge pclk) disable iff (!presetn) // RL3
        st_r.sensor_b_over_range == $past(temp_b > OVER_RANGE_C))
        else $error("sensor B over-range flag wrong");

    AST_OVR_A_READ: assert property (@(posedge pclk) disable iff (!presetn) // RL2
        (setup && sel == REG_SAMPLE_LO)
        |=> apb_rsp.prdata[OVR_A_BIT] == $past(st_r.sensor_a_over_range)
            && apb_rsp.prdata[31:26] == 6'h0)
        else $error("sensor A over-range flag not at its bit");

    AST_HOLD_TORN: assert property (@(posedge pclk) disable iff (!presetn) // RL4
        (raw_a_s != st_r.raw_a_last) |=> st_r.raw_a_ok == $past(st_r.raw_a_ok))
        else $error("reading taken before two samples agreed");

    AST_HIGH_UPPER: assert property (@(posedge pclk) disable iff (!presetn) // RL11
        (wr && sel == REG_HICFG_HI && apb_req.pstrb == 4'hf)
        |=> st_r.high_alarm_config[63:32] == ($past(apb_req.pwdata) & CFG_WMASK[63:32]))
        else $error("high alarm groups 2 and 3 write not stored");

    AST_LOW_CFG: assert property (@(posedge pclk) disable iff (!presetn) // RL12
        (wr && sel == REG_LOCFG_LO && apb_req.pstrb == 4'hf)
        |=> st_r.low_alarm_config[31:0] == ($past(apb_req.pwdata) & CFG_WMASK[31:0]))
        else $error("low alarm groups 0 and 1 write not stored");

    AST_LOW_UPPER: assert property (@(posedge pclk) disable iff (!presetn) // RL12
        (wr && sel == REG_LOCFG_HI && apb_req.pstrb == 4'hf)
        |=> st_r.low_alarm_config[63:32] == ($past(apb_req.pwdata) & CFG_WMASK[63:32]))
        else $error("low alarm groups 2 and 3 write not stored");

    AST_SOURCE_B: assert property (@(posedge pclk) disable iff (!presetn) // RL9
        (st_r.low_alarm_config[ARM_BIT] && st_r.low_alarm_config[SRC_LSB] == 1'b1
            && temp_b >= $signed(st_r.low_alarm_config[7:0])) |-> !low_hit[0])
        else $error("low group 0 followed the wrong sensor");

    AST_PEND_READ: assert property (@(posedge pclk) disable iff (!presetn) // RL13
        (setup && sel == REG_PEND_LO)
        |=> apb_rsp.prdata == {30'h0, $past(st_r.alarm_pending_flags)})
        else $error("pending flags read back wrong");

    AST_CLEAR_HIGH: assert property (@(posedge pclk) disable iff (!presetn) // RL14
        (pend_clr && !high_any) |=> !st_r.alarm_pending_flags[PEND_HIGH_BIT])
        else $error("high flag survived a status write");

    AST_LOW_IRQ: assert property (@(posedge pclk) disable iff (!presetn) // RL16
        low_any |=> thermal_irq || !st_r.irq_mask[PEND_LOW_BIT])
        else $error("low alarm did not raise the interrupt");

endmodule // tmon_core

`default_nettype wire

/* logic/tmon_pkg.sv */
// Shared constants, types and helper functions of the thermal monitor.
`default_nettype none

package tmon_pkg;

    // Register word addresses; each 64-bit register spans two aligned words.
    localparam logic [31:0] ADDR_SAMPLE_LO = 32'h1fe00198;
    localparam logic [31:0] ADDR_SAMPLE_HI = 32'h1fe0019c;
    localparam logic [31:0] ADDR_HICFG_LO = 32'h3ff01460;
    localparam logic [31:0] ADDR_HICFG_HI = 32'h3ff01464;
    localparam logic [31:0] ADDR_LOCFG_LO = 32'h3ff01468;
    localparam logic [31:0] ADDR_LOCFG_HI = 32'h3ff0146c;
    localparam logic [31:0] ADDR_PEND_LO = 32'h3ff01470;
    localparam logic [31:0] ADDR_PEND_HI = 32'h3ff01474;
    localparam logic [31:0] ADDR_MASK = 32'h3ff01478;

    // Alarm group layout inside a 64-bit configuration register.
    localparam int GROUPS = 4;
    localparam int GRP_STEP = 16;
    localparam int LIMIT_LSB = 0;
    localparam int LIMIT_W = 8;
    localparam int ARM_BIT = 8;
    localparam int SRC_LSB = 10;
    localparam int SRC_W = 2;
    localparam logic [63:0] CFG_WMASK = 64'h0dff_0dff_0dff_0dff;
    localparam logic [63:0] CFG_RESET = 64'h0000_0000_0000_0000;

    // Pending flags, mask and sample register fields.
    localparam int PEND_HIGH_BIT = 0;
    localparam int PEND_LOW_BIT = 1;
    localparam logic [1:0] PEND_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h3;
    localparam int OVR_A_BIT = 24;
    localparam int OVR_B_BIT = 25;
    localparam int RAW_W = 16;
    localparam logic [RAW_W-1:0] RAW_RESET = 16'h0000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // Conversion: celsius = raw * 731 / 0x4000 - 273.
    localparam logic [9:0] RAW_GAIN = 10'h2db;
    localparam int RAW_SHIFT = 14;
    localparam logic signed [12:0] TEMP_OFFSET_C = 13'sh111;
    localparam logic signed [12:0] OVER_RANGE_C = 13'sh07d;

    typedef enum logic [3:0] {
        REG_NONE = 4'h0,
        REG_SAMPLE_LO = 4'h1,
        REG_SAMPLE_HI = 4'h2,
        REG_HICFG_LO = 4'h3,
        REG_HICFG_HI = 4'h4,
        REG_LOCFG_LO = 4'h5,
        REG_LOCFG_HI = 4'h6,
        REG_PEND_LO = 4'h7,
        REG_PEND_HI = 4'h8,
        REG_MASK = 4'h9
    } tmon_reg_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } tmon_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tmon_apb_rsp_s;

    typedef struct packed {
        logic [RAW_W-1:0] meta;
        logic [RAW_W-1:0] stable;
    } tmon_sync_s;

    function automatic logic signed [12:0] raw_to_celsius(input logic [RAW_W-1:0] raw);
        logic [25:0] prod;
        prod = 26'(raw) * 26'(RAW_GAIN);
        return $signed({1'b0, prod[25:RAW_SHIFT]}) - TEMP_OFFSET_C;
    endfunction

    function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

`default_nettype wire

/* logic/tmon_sync.sv */
// Two-stage synchroniser for a raw sensor reading.
`default_nettype none

module tmon_sync
    import tmon_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [RAW_W-1:0] async_in,
    output logic [RAW_W-1:0] sync_out
);

    tmon_sync_s st_r;
    tmon_sync_s st_nxt;

    always_comb begin
        st_nxt.meta = async_in;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{meta: RAW_RESET, stable: RAW_RESET};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stable;

endmodule // tmon_sync

`default_nettype wire

/* verif/tb_tmon_core.sv */
// Self-checking testbench of the thermal monitor core.
`default_nettype none
`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[FAIL] %0t %s", $time, msg); end end

module tb_tmon_core
    import tmon_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    tmon_apb_req_s req = '0;
    tmon_apb_rsp_s rsp;
    logic signed [12:0] temp_a = 13'sh019;
    logic signed [12:0] temp_b = 13'sh019;
    logic [RAW_W-1:0] raw_a;
    logic [RAW_W-1:0] raw_b;
    logic irq;
    logic [31:0] rd;
    logic err;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;

    always #5 pclk = ~pclk;

    tmon_sens_model sens (.temp_a_c(temp_a), .temp_b_c(temp_b),
        .sensor_a_raw(raw_a), .sensor_b_raw(raw_b));

    tmon_core DUT (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .sensor_a_raw(raw_a), .sensor_b_raw(raw_b), .thermal_irq(irq));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            $display("[FAIL] %0t timeout", $time);
            give_verdict();
        end
    end

    // One APB transfer; the request is held until pready is seen high at a rising edge.
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                        input logic [3:0] strb = 4'hf);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata, pstrb: strb};
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (rsp.pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic chk_rd(input logic [31:0] addr, input logic [31:0] exp, input string msg);
        xfer(1'b0, addr, 32'h0);
        `CHK(rd, exp, msg)
    endtask

    task automatic put(input logic signed [12:0] a, input logic signed [12:0] b);
        temp_a <= a;
        temp_b <= b;
        repeat (5) @(posedge pclk);
    endtask

    function automatic logic [63:0] grp_cfg(int g, logic [7:0] lim, logic arm, logic [1:0] src);
        return 64'({src, 1'b0, arm, lim}) << (g * 16);
    endfunction

    task automatic set_cfg(input logic [31:0] base, input logic [63:0] v);
        xfer(1'b1, base, v[31:0]);
        xfer(1'b1, base + 32'h4, v[63:32]);
    endtask

    task automatic test_reset();
        chk_rd(ADDR_HICFG_LO, 32'h0, "high cfg reset");
        chk_rd(ADDR_LOCFG_HI, 32'h0, "low cfg reset");
        chk_rd(ADDR_PEND_LO, 32'h0, "pending reset");
        `CHK(err, 1'b0, "error on mapped read")
        chk_rd(ADDR_MASK, 32'h3, "mask reset");
        `CHK(irq, 1'b0, "irq after reset")
        chk_rd(32'h3ff0147c, 32'h0, "unmapped read data");
        `CHK(err, 1'b1, "unmapped without error")
        $display("test_reset done");
    endtask

    task automatic test_sample();
        put(13'sh019, 13'sh07e);
        chk_rd(ADDR_SAMPLE_LO, 32'h0200_0000, "sensor b over range");
        xfer(1'b1, ADDR_SAMPLE_HI, 32'hffff_ffff);
        chk_rd(ADDR_SAMPLE_HI, 32'h22ef_1a18, "raw pair");
        put(13'sh07d, 13'sh019);
        chk_rd(ADDR_SAMPLE_LO, 32'h0, "125 degrees flagged");
        put(13'sh07e, 13'sh019);
        chk_rd(ADDR_SAMPLE_LO, 32'h0100_0000, "sensor a over range");
        put(13'sh019, 13'sh019);
        $display("test_sample done");
    endtask

    task automatic test_layout();
        set_cfg(ADDR_HICFG_LO, '1);
        chk_rd(ADDR_HICFG_LO, 32'h0dff_0dff, "high groups 0 1 layout");
        chk_rd(ADDR_HICFG_HI, 32'h0dff_0dff, "high groups 2 3 layout");
        set_cfg(ADDR_LOCFG_LO, '1);
        chk_rd(ADDR_LOCFG_LO, 32'h0dff_0dff, "low groups 0 1 layout");
        chk_rd(ADDR_LOCFG_HI, 32'h0dff_0dff, "low groups 2 3 layout");
        set_cfg(ADDR_HICFG_LO, '0);
        xfer(1'b1, ADDR_HICFG_LO, 32'hffff_ffff, 4'h2);
        chk_rd(ADDR_HICFG_LO, 32'h0000_0d00, "byte strobe not honoured");
        xfer(1'b1, ADDR_HICFG_LO, 32'h0);
        set_cfg(ADDR_LOCFG_LO, '0);
        xfer(1'b1, ADDR_PEND_LO, 32'h0);
        $display("test_layout done");
    endtask

    // Disarmed, equal-to-limit and wrong-source cases must stay quiet before the real hit.
    task automatic run_group(input bit high, input int g, input logic [1:0] src);
        logic [31:0] base;
        logic [31:0] bexp;
        logic signed [12:0] lim;
        logic signed [12:0] fire;
        base = high ? ADDR_HICFG_LO : ADDR_LOCFG_LO;
        bexp = high ? 32'h1 : 32'h2;
        lim = high ? 13'sh032 : 13'sh000;
        fire = high ? 13'sh033 : -13'sh001;
        set_cfg(base, grp_cfg(g, lim[7:0], 1'b0, src));
        put(fire, fire);
        chk_rd(ADDR_PEND_LO, 32'h0, "disarmed group fired");
        put(src == 2'h0 ? lim : fire, src == 2'h0 ? fire : lim);
        set_cfg(base, grp_cfg(g, lim[7:0], 1'b1, src));
        chk_rd(ADDR_PEND_LO, 32'h0, "limit or other sensor fired");
        put(src == 2'h0 ? fire : lim, src == 2'h0 ? lim : fire);
        chk_rd(ADDR_PEND_LO, bexp, "armed group silent");
        `CHK(irq, 1'b1, "irq not raised")
        xfer(1'b1, ADDR_PEND_LO, 32'h0);
        chk_rd(ADDR_PEND_LO, bexp, "clear beat a true condition");
        put(lim, lim);
        chk_rd(ADDR_PEND_LO, bexp, "flag not sticky");
        xfer(1'b1, ADDR_PEND_HI, 32'h1234_5678);
        chk_rd(ADDR_PEND_LO, 32'h0, "write did not clear");
        `CHK(irq, 1'b0, "irq stuck")
        set_cfg(base, '0);
    endtask

    task automatic test_groups();
        for (int k = 0; k < 2; k++) begin
            for (int g = 0; g < GROUPS; g++) begin
                run_group(k == 0, g, 2'h0);
                run_group(k == 0, g, 2'h1);
            end
        end
        $display("test_groups done");
    endtask

    task automatic test_mask();
        set_cfg(ADDR_HICFG_LO, grp_cfg(0, 8'h32, 1'b1, 2'h0));
        xfer(1'b1, ADDR_MASK, 32'h0);
        put(13'sh033, 13'sh019);
        chk_rd(ADDR_PEND_LO, 32'h1, "masked flag not latched");
        `CHK(irq, 1'b0, "masked irq raised")
        xfer(1'b1, ADDR_MASK, 32'h1);
        chk_rd(ADDR_MASK, 32'h1, "mask readback");
        `CHK(irq, 1'b1, "unmasked irq low")
        put(13'sh019, 13'sh019);
        set_cfg(ADDR_HICFG_LO, '0);
        xfer(1'b1, ADDR_PEND_LO, 32'h0);
        `CHK(irq, 1'b0, "irq after clear")
        $display("test_mask done");
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        test_reset();
        test_sample();
        test_layout();
        test_groups();
        test_mask();
        give_verdict();
    end
endmodule // tb_tmon_core

`default_nettype wire

/* verif/tmon_sens_model.sv */
// Behavioural model of the two analog temperature sensors feeding the monitor.
`default_nettype none

module tmon_sens_model
    import tmon_pkg::*;
(
    input wire logic signed [12:0] temp_a_c,
    input wire logic signed [12:0] temp_b_c,
    output logic [RAW_W-1:0] sensor_a_raw,
    output logic [RAW_W-1:0] sensor_b_raw
);
    timeunit 1ns;
    timeprecision 1ps;

    // Smallest raw code whose conversion lands exactly on the requested whole degree.
    function automatic logic [RAW_W-1:0] to_raw(input logic signed [12:0] c);
        int n;
        n = (int'(c) + 273) * 16384;
        return RAW_W'((n + 730) / 731);
    endfunction

    assign sensor_a_raw = to_raw(temp_a_c);
    assign sensor_b_raw = to_raw(temp_b_c);
endmodule // tmon_sens_model

`default_nettype wire
